// [rtl/cph_cfg_ctrl.sv]
`timescale 1ns/100ps
// Operation
// RULE1: Raise power-change notice when a PM control write moves a function to D1/D3.
// RULE2: Keep the notice high until the acknowledge input is seen.
// RULE3: Withhold all pending configuration completions while the notice is high.
// RULE4: Present the changing function's index while the notice is high.
// RULE5: After acknowledge, show the new state on the PF or VF state output.
// RULE6: User pulses correctable-fault input for exactly one cycle.
// RULE7: Correctable pulse sets corrected-internal status of enabled functions; message if enabled.
// RULE8: User pulses uncorrectable-fault input for exactly one cycle.
// RULE9: Uncorrectable pulse sets uncorrected-internal status of enabled functions; message if enabled.
// RULE10: User sets reset-finished bit i when physical function i reset completes.
// RULE11: Reset-finished bit i clears reset-pending bit i.
// RULE12: Reset-finished bit i re-enables configuration access to function i.
// RULE13: User pulses acknowledge once ready, or ties it high.
// RULE14: Raise reset-pending bit i when host sets function i's reset bit.
// RULE15: Hold each reset-pending bit until the matching reset-finished bit.
// RULE16: Drop notice the edge after acknowledge, then release completions in order.
module cph_cfg_ctrl
    import cph_pkg::*;
#(
    parameter int unsigned TAG_W = 8,
    parameter int unsigned QDEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Configuration requests from the link side
    input wire logic req_valid_in,
    input wire logic req_write_in,
    input wire logic [FN_W-1:0] req_func_in,
    input wire logic [TAG_W-1:0] req_tag_in,
    input wire logic req_pm_wr_in,
    input wire logic [PS_W-1:0] req_pm_state_in,
    input wire logic req_flr_wr_in,
    output logic req_ready_out,
    output logic req_refused_out,
    // Completions back to the link side
    output logic cpl_valid_out,
    output logic [TAG_W-1:0] cpl_tag_out,
    input wire logic cpl_ready_in,
    // Power-change handshake
    output logic power_change_notice_out,
    input wire logic power_change_ack_in,
    output logic [FN_W-1:0] func_index_out,
    output logic [NUM_PF*PS_W-1:0] pf_power_state_out,
    output logic [NUM_VF*PS_W-1:0] virt_func_power_level_out,
    // Internal error reporting
    input wire logic cor_fault_in,
    input wire logic uncor_fault_in,
    input wire logic [NUM_FN-1:0] func_enable_in,
    input wire logic [NUM_FN-1:0] cor_msg_enable_in,
    input wire logic [NUM_FN-1:0] uncor_msg_enable_in,
    input wire logic [NUM_FN-1:0] aer_cor_clear_in,
    input wire logic [NUM_FN-1:0] aer_uncor_clear_in,
    output logic [NUM_FN-1:0] aer_cor_status_out,
    output logic [NUM_FN-1:0] aer_uncor_status_out,
    output logic cor_msg_out,
    output logic uncor_msg_out,
    // Function-level reset
    input wire logic [NUM_PF-1:0] flr_done_in,
    output logic [NUM_PF-1:0] flr_pending_out
);
    localparam int unsigned PTR_W = $clog2(QDEPTH);
    localparam logic [PTR_W:0] Q_FULL = (PTR_W+1)'(QDEPTH);
    localparam logic [PTR_W:0] Q_ONE = (PTR_W+1)'(1);
    localparam logic [PTR_W-1:0] P_ONE = PTR_W'(1);

    typedef struct packed {
        cph_pwr_t pwr;
        logic [FN_W-1:0] func_idx;
        logic [PS_W-1:0] new_ps;
        logic [NUM_PF-1:0][PS_W-1:0] pf_ps;
        logic [NUM_VF-1:0][PS_W-1:0] vf_ps;
        logic [NUM_FN-1:0] cor_st;
        logic [NUM_FN-1:0] unc_st;
        logic cor_msg;
        logic unc_msg;
        logic [NUM_PF-1:0] flr_pend;
        logic refused;
        logic [PTR_W-1:0] head;
        logic [PTR_W-1:0] tail;
        logic [PTR_W:0] count;
    } cph_state_t;

    cph_state_t s_q;
    cph_state_t s_d;
    logic push;
    logic pop;
    logic blocked;
    logic pm_low;
    logic [NUM_PF-1:0] flr_set;

    cph_queue_if #(.TAG_W(TAG_W), .PTR_W(PTR_W)) q_if ();

    // Writes a power state into the PF or VF slot selected by a function index
    function automatic cph_state_t set_ps(cph_state_t s, logic [FN_W-1:0] idx,
                                          logic [PS_W-1:0] ps);
        cph_state_t r;
        logic [FN_W-1:0] vidx;
        r = s;
        vidx = idx - FN_FIRST_VF;
        if (idx < FN_FIRST_VF) begin
            r.pf_ps[idx[0]] = ps;
        end else if (idx < FN_LIMIT) begin
            r.vf_ps[vidx[2:0]] = ps;
        end
        return r;
    endfunction : set_ps

    // Request decode
    assign req_ready_out = (s_q.count != Q_FULL) && (s_q.pwr == PW_IDLE);
    assign push = req_valid_in && req_ready_out;
    assign blocked = (req_func_in < FN_FIRST_VF) && s_q.flr_pend[req_func_in[0]]; // see RULE12
    assign pm_low = req_write_in && req_pm_wr_in &&
        ((req_pm_state_in == PS_D1) || (req_pm_state_in == PS_D3));
    assign pop = (s_q.count != '0) && (s_q.pwr == PW_IDLE) && cpl_ready_in; // see RULE3

    // Reset-pending set vector from host reset-bit writes
    always_comb begin
        flr_set = '0;
        if (push && !blocked && req_write_in && req_flr_wr_in && (req_func_in < FN_FIRST_VF)) begin
            flr_set[req_func_in[0]] = 1'b1; // see RULE14
        end
    end

    // Next-state logic
    always_comb begin
        s_d = s_q;
        s_d.cor_msg = 1'b0;
        s_d.unc_msg = 1'b0;
        s_d.refused = push && blocked;
        // Queue bookkeeping; blocked requests never enter the queue
        if (push && !blocked) begin
            s_d.tail = s_q.tail + P_ONE;
        end
        if (pop) begin
            s_d.head = s_q.head + P_ONE; // see RULE16
        end
        s_d.count = s_q.count + ((push && !blocked) ? Q_ONE : '0) - (pop ? Q_ONE : '0);
        // Power-change handshake
        unique case (s_q.pwr)
            PW_IDLE: begin
                if (push && !blocked && req_write_in && req_pm_wr_in) begin
                    if (pm_low) begin
                        s_d.pwr = PW_HOLD; // see RULE1
                        s_d.func_idx = req_func_in; // see RULE4
                        s_d.new_ps = req_pm_state_in;
                    end else begin
                        s_d = set_ps(s_d, req_func_in, req_pm_state_in);
                    end
                end
            end
            PW_HOLD: begin
                if (power_change_ack_in) begin // see RULE2
                    s_d.pwr = PW_IDLE; // see RULE16
                    s_d = set_ps(s_d, s_q.func_idx, s_q.new_ps); // see RULE5
                end
            end
        endcase
        // Sticky internal-error status, a new fault beats a same-cycle clear
        s_d.cor_st = (s_q.cor_st & ~aer_cor_clear_in) |
            ({NUM_FN{cor_fault_in}} & func_enable_in); // see RULE7
        s_d.unc_st = (s_q.unc_st & ~aer_uncor_clear_in) |
            ({NUM_FN{uncor_fault_in}} & func_enable_in); // see RULE9
        s_d.cor_msg = cor_fault_in && |(func_enable_in & cor_msg_enable_in); // see RULE7
        s_d.unc_msg = uncor_fault_in && |(func_enable_in & uncor_msg_enable_in); // see RULE9
        // Reset-pending flags, a new reset beats a same-cycle finish
        s_d.flr_pend = (s_q.flr_pend & ~flr_done_in) | flr_set; // see RULE11 RULE15
    end

    // State register
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '{pwr: PW_IDLE, func_idx: FN_RESET, new_ps: PS_RESET,
                     pf_ps: {NUM_PF{PS_RESET}}, vf_ps: {NUM_VF{PS_RESET}},
                     cor_st: ERR_RESET, unc_st: ERR_RESET, cor_msg: 1'b0,
                     unc_msg: 1'b0, flr_pend: FLR_RESET, refused: 1'b0,
                     head: '0, tail: '0, count: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Withheld-completion store, read address runs one step ahead
    assign q_if.wr_en = push && !blocked;
    assign q_if.wr_addr = s_q.tail;
    assign q_if.wr_data = req_tag_in;
    assign q_if.rd_addr = s_d.head;

    cph_tag_mem #(.DEPTH(QDEPTH)) u_tag_mem (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .q(q_if.store)
    );

    // Outputs
    assign cpl_valid_out = (s_q.count != '0) && (s_q.pwr == PW_IDLE); // see RULE3
    assign cpl_tag_out = q_if.rd_data;
    assign req_refused_out = s_q.refused;
    assign power_change_notice_out = (s_q.pwr == PW_HOLD);
    assign func_index_out = s_q.func_idx;
    assign pf_power_state_out = s_q.pf_ps;
    assign virt_func_power_level_out = s_q.vf_ps;
    assign aer_cor_status_out = s_q.cor_st;
    assign aer_uncor_status_out = s_q.unc_st;
    assign cor_msg_out = s_q.cor_msg;
    assign uncor_msg_out = s_q.unc_msg;
    assign flr_pending_out = s_q.flr_pend;

    // Checks
    a_notice_raise: assert property (@(posedge ref_clk_in) // see RULE1
        disable iff (!rst_n_in) (push && !blocked && pm_low) |=> power_change_notice_out)
        else $error("power-change notice not raised");
    a_notice_hold: assert property (@(posedge ref_clk_in) // see RULE2
        disable iff (!rst_n_in)
        (power_change_notice_out && !power_change_ack_in) |=> power_change_notice_out)
        else $error("notice dropped without acknowledge");
    a_cpl_withheld: assert property (@(posedge ref_clk_in) // see RULE3
        disable iff (!rst_n_in) power_change_notice_out |-> !cpl_valid_out)
        else $error("completion released during notice");
    a_func_index: assert property (@(posedge ref_clk_in) // see RULE4
        disable iff (!rst_n_in)
        $rose(power_change_notice_out) |-> (func_index_out == $past(req_func_in)))
        else $error("wrong function index with notice");
    a_pf_state_update: assert property (@(posedge ref_clk_in) // see RULE5
        disable iff (!rst_n_in)
        (power_change_notice_out && power_change_ack_in && (func_index_out == 8'h01))
        |=> (pf_power_state_out[PS_W+:PS_W] == $past(s_q.new_ps)))
        else $error("PF1 power state not updated");
    a_notice_drop: assert property (@(posedge ref_clk_in) // see RULE16
        disable iff (!rst_n_in) (power_change_notice_out && power_change_ack_in)
        |=> (!power_change_notice_out && ((s_q.count == '0) || cpl_valid_out)))
        else $error("notice kept or completions not released after acknowledge");
    a_cor_status: assert property (@(posedge ref_clk_in) // see RULE7
        disable iff (!rst_n_in) (cor_fault_in && func_enable_in[1]) |=> aer_cor_status_out[1])
        else $error("corrected internal status not set");
    a_uncor_msg: assert property (@(posedge ref_clk_in) // see RULE9
        disable iff (!rst_n_in)
        (uncor_fault_in && |(func_enable_in & uncor_msg_enable_in)) |=> uncor_msg_out)
        else $error("uncorrectable message not sent");
    a_flr_release: assert property (@(posedge ref_clk_in) // see RULE11
        disable iff (!rst_n_in) (flr_done_in[1] && !flr_set[1]) |=> !flr_pending_out[1])
        else $error("reset-pending not cleared");
    a_flr_block: assert property (@(posedge ref_clk_in) // see RULE12
        disable iff (!rst_n_in) (push && blocked) |-> (!q_if.wr_en ##1 req_refused_out))
        else $error("access to resetting function accepted");
    a_flr_raise: assert property (@(posedge ref_clk_in) // see RULE14
        disable iff (!rst_n_in) flr_set[1] |=> flr_pending_out[1])
        else $error("reset-pending not raised");
    a_flr_hold: assert property (@(posedge ref_clk_in) // see RULE15
        disable iff (!rst_n_in) (flr_pending_out[1] && !flr_done_in[1]) |=> flr_pending_out[1])
        else $error("reset-pending dropped early");
endmodule : cph_cfg_ctrl

// [include/cph_pkg.sv]
package cph_pkg;
    // Function layout: indices 0..1 are physical, 2..7 are virtual
    localparam int unsigned NUM_PF = 2;
    localparam int unsigned NUM_VF = 6;
    localparam int unsigned NUM_FN = 8;
    localparam int unsigned FN_W = 8;
    localparam int unsigned PS_W = 2;
    localparam logic [FN_W-1:0] FN_FIRST_VF = 8'h02;
    localparam logic [FN_W-1:0] FN_LIMIT = 8'h08;

    // Power state encoding and value after reset
    localparam logic [PS_W-1:0] PS_D0 = 2'h0;
    localparam logic [PS_W-1:0] PS_D1 = 2'h1;
    localparam logic [PS_W-1:0] PS_D2 = 2'h2;
    localparam logic [PS_W-1:0] PS_D3 = 2'h3;
    localparam logic [PS_W-1:0] PS_RESET = PS_D0;

    // Reset values of index and flag fields
    localparam logic [FN_W-1:0] FN_RESET = 8'h00;
    localparam logic [NUM_FN-1:0] ERR_RESET = 8'h00;
    localparam logic [NUM_PF-1:0] FLR_RESET = 2'h0;

    // Power-change handshake state
    typedef enum logic {
        PW_IDLE,
        PW_HOLD
    } cph_pwr_t;
endpackage : cph_pkg

// [include/cph_queue_if.sv]
`timescale 1ns/100ps
// Write and read port of the withheld-completion store
interface cph_queue_if #(
    parameter int unsigned TAG_W = 8,
    parameter int unsigned PTR_W = 3
);
    logic wr_en;
    logic [PTR_W-1:0] wr_addr;
    logic [TAG_W-1:0] wr_data;
    logic [PTR_W-1:0] rd_addr;
    logic [TAG_W-1:0] rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
        input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
        output rd_data);
endinterface : cph_queue_if

// [rtl/cph_tag_mem.sv]
`timescale 1ns/100ps
module cph_tag_mem #(
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Store port
    cph_queue_if.store q
);
    logic [$bits(q.wr_data)-1:0] mem_q [DEPTH];
    logic [$bits(q.wr_data)-1:0] rd_q;

    // Storage array, written without reset
    always_ff @(posedge ref_clk_in) begin
        if (q.wr_en) begin
            mem_q[q.wr_addr] <= q.wr_data;
        end
    end

    // Registered read; a write to the slot being read passes straight through
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_q <= '0;
        end else if (q.wr_en && (q.wr_addr == q.rd_addr)) begin
            rd_q <= q.wr_data;
        end else begin
            rd_q <= mem_q[q.rd_addr];
        end
    end

    assign q.rd_data = rd_q;
endmodule : cph_tag_mem

// [tb/cph_user_model.sv]
`timescale 1ns/100ps
// Stand-in for the user logic beside the block
module cph_user_model
    import cph_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // Commands from the bench
    input wire logic [3:0] ack_wait_in,
    input wire logic cor_go_in,
    input wire logic uncor_go_in,
    input wire logic [NUM_PF-1:0] flr_go_in,
    // Handshakes with the block
    input wire logic notice_in,
    output logic ack_out,
    output logic cor_fault_out,
    output logic uncor_fault_out,
    output logic [NUM_PF-1:0] flr_done_out
);
    logic [3:0] wait_q;
    // Ack pulse after a chosen wait, faults as single pulses, done as a level
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wait_q <= 4'h0;
            ack_out <= 1'b0;
            cor_fault_out <= 1'b0;
            uncor_fault_out <= 1'b0;
            flr_done_out <= 2'h0;
        end else begin
            ack_out <= notice_in && !ack_out && wait_q == ack_wait_in;
            wait_q <= (notice_in && !ack_out) ? wait_q + 4'h1 : 4'h0;
            cor_fault_out <= cor_go_in && !cor_fault_out;
            uncor_fault_out <= uncor_go_in && !uncor_fault_out;
            flr_done_out <= flr_go_in;
        end
    end
endmodule : cph_user_model

// [tb/cph_cfg_ctrl_bench.sv]
`timescale 1ns/100ps
// Self-checking bench for the configuration handshake block
module cph_cfg_ctrl_bench;
    import cph_pkg::*;
    logic ref_clk_in, rst_n_in, req_valid_in, req_write_in, req_pm_wr_in, req_flr_wr_in;
    logic req_ready_out, req_refused_out, cpl_valid_out, cpl_ready_in, cor_msg_out;
    logic power_change_notice_out, power_change_ack_in, cor_fault_in, uncor_fault_in;
    logic uncor_msg_out, cor_go, uncor_go;
    logic [7:0] req_func_in, func_index_out, req_tag_in, cpl_tag_out, func_enable_in;
    logic [7:0] cor_msg_enable_in, uncor_msg_enable_in, aer_cor_clear_in, aer_uncor_clear_in;
    logic [7:0] aer_cor_status_out, aer_uncor_status_out;
    logic [1:0] req_pm_state_in, flr_done_in, flr_pending_out, flr_go;
    logic [3:0] pf_power_state_out, ack_wait;
    logic [11:0] virt_func_power_level_out;
    logic [15:0] ps_exp;
    int bad_count, num_checks, cycles;

    // Block under test and the user-side model
    cph_cfg_ctrl #(.TAG_W(8), .QDEPTH(8)) uut (.ref_clk_in, .rst_n_in, .req_valid_in,
        .req_write_in, .req_func_in, .req_tag_in, .req_pm_wr_in, .req_pm_state_in,
        .req_flr_wr_in, .req_ready_out, .req_refused_out, .cpl_valid_out, .cpl_tag_out,
        .cpl_ready_in, .power_change_notice_out, .power_change_ack_in, .func_index_out,
        .pf_power_state_out, .virt_func_power_level_out, .cor_fault_in, .uncor_fault_in,
        .func_enable_in, .cor_msg_enable_in, .uncor_msg_enable_in, .aer_cor_clear_in,
        .aer_uncor_clear_in, .aer_cor_status_out, .aer_uncor_status_out, .cor_msg_out,
        .uncor_msg_out, .flr_done_in, .flr_pending_out);
    cph_user_model user (.ref_clk_in, .rst_n_in, .ack_wait_in(ack_wait), .cor_go_in(cor_go),
        .uncor_go_in(uncor_go), .flr_go_in(flr_go), .notice_in(power_change_notice_out),
        .ack_out(power_change_ack_in), .cor_fault_out(cor_fault_in),
        .uncor_fault_out(uncor_fault_in), .flr_done_out(flr_done_in));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // One request, held until the block takes it
    task automatic send(input logic w, input logic [7:0] f, input logic [7:0] t,
        input logic pm, input logic [1:0] s, input logic fl);
        int n;
        n = 0;
        @(posedge ref_clk_in);
        {req_valid_in, req_write_in, req_pm_wr_in, req_flr_wr_in} <= {1'b1, w, pm, fl};
        {req_func_in, req_tag_in, req_pm_state_in} <= {f, t, s};
        do @(negedge ref_clk_in); while (req_ready_out !== 1'b1 && ++n < 50);
        chk(req_ready_out, 1'b1, "request taken");
        @(posedge ref_clk_in);
        req_valid_in <= 1'b0;
    endtask : send

    // Take the next completion and compare its tag
    task automatic pop(input logic [7:0] t);
        int n;
        n = 0;
        do @(negedge ref_clk_in); while (cpl_valid_out !== 1'b1 && ++n < 50);
        chk(cpl_valid_out, 1'b1, "completion offered");
        chk(cpl_tag_out, t, "completion tag");
        @(posedge ref_clk_in);
        cpl_ready_in <= 1'b1;
        @(posedge ref_clk_in);
        cpl_ready_in <= 1'b0;
    endtask : pop

    // Queued read, then a power write; user acks after w cycles
    task automatic pwr_case(input logic [7:0] f, input logic [1:0] s, input logic [3:0] w);
        int n;
        n = 0;
        ack_wait <= w;
        send(1'b0, 8'h00, 8'h11, 1'b0, PS_D0, 1'b0);
        send(1'b1, f, 8'h22, 1'b1, s, 1'b0);
        @(negedge ref_clk_in);
        chk(power_change_notice_out, s[0], "notice");
        if (s[0]) begin
            chk(func_index_out, f, "function index");
            chk({virt_func_power_level_out, pf_power_state_out}, ps_exp, "early state");
            while (power_change_notice_out === 1'b1 && n++ < 20) begin
                chk(cpl_valid_out, 1'b0, "completion held");
                @(negedge ref_clk_in);
            end
            chk(16'(n), 16'(w) + 16'h0002, "notice length");
        end
        ps_exp[f*2+:2] = s;
        chk({virt_func_power_level_out, pf_power_state_out}, ps_exp, "new state");
        pop(8'h11);
        pop(8'h22);
    endtask : pwr_case

    // One user fault pulse, then clear of all status
    task automatic err_case(input logic unc, input logic [7:0] en, input logic [7:0] me);
        @(posedge ref_clk_in);
        {func_enable_in, cor_msg_enable_in, uncor_msg_enable_in} <= {en, me, me};
        {cor_go, uncor_go} <= {!unc, unc};
        @(posedge ref_clk_in);
        {cor_go, uncor_go} <= 2'h0;
        @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk({aer_uncor_status_out, aer_cor_status_out}, unc ? {en, 8'h00} : {8'h00, en},
            "status");
        chk({uncor_msg_out, cor_msg_out}, {unc, !unc} & {2{|(en & me)}}, "message");
        @(posedge ref_clk_in);
        {aer_cor_clear_in, aer_uncor_clear_in} <= 16'hffff;
        @(posedge ref_clk_in);
        {aer_cor_clear_in, aer_uncor_clear_in} <= 16'h0000;
        @(negedge ref_clk_in);
        chk({aer_uncor_status_out, aer_cor_status_out}, 16'h0, "cleared");
        chk({uncor_msg_out, cor_msg_out}, 16'h0, "message ended");
    endtask : err_case

    // Reset of function 1: pending, refused access, release
    task automatic flr_case();
        send(1'b1, 8'h01, 8'h33, 1'b0, PS_D0, 1'b1);
        @(negedge ref_clk_in);
        chk(flr_pending_out, 2'h2, "pending set");
        pop(8'h33);
        send(1'b0, 8'h01, 8'h44, 1'b0, PS_D0, 1'b0);
        @(negedge ref_clk_in);
        chk({req_refused_out, cpl_valid_out, flr_pending_out}, 16'h0a, "blocked");
        @(posedge ref_clk_in);
        flr_go <= 2'h2;
        repeat (3) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
        chk(flr_pending_out, 2'h0, "pending dropped");
        send(1'b0, 8'h01, 8'h55, 1'b0, PS_D0, 1'b0);
        @(negedge ref_clk_in);
        chk(req_refused_out, 1'b0, "accepted again");
        pop(8'h55);
        flr_go <= 2'h0;
    endtask : flr_case

    // Clock generator
    initial begin
        ref_clk_in = 1'b0;
        forever #12.5 ref_clk_in = ~ref_clk_in;
    end

    // Hang guard
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            stop_test();
        end
    end

    // Main sequence
    initial begin
        rst_n_in = 1'b0;
        {req_valid_in, req_write_in, req_pm_wr_in, req_flr_wr_in, cpl_ready_in} = 5'h0;
        {req_func_in, req_tag_in, req_pm_state_in, flr_go, ack_wait} = 24'h0;
        {func_enable_in, cor_msg_enable_in, uncor_msg_enable_in} = 24'h0;
        {aer_cor_clear_in, aer_uncor_clear_in, cor_go, uncor_go} = 18'h0;
        ps_exp = 16'h0;
        repeat (10) @(posedge ref_clk_in);
        chk({req_ready_out, power_change_notice_out, flr_pending_out}, 16'h8, "reset");
        rst_n_in <= 1'b1;
        pwr_case(8'h02, PS_D3, 4'h0);
        pwr_case(8'h01, PS_D1, 4'h3);
        pwr_case(8'h07, PS_D1, 4'h1);
        pwr_case(8'h00, PS_D2, 4'h0);
        err_case(1'b0, 8'h5a, 8'h02);
        err_case(1'b1, 8'h81, 8'h40);
        err_case(1'b1, 8'h81, 8'h01);
        flr_case();
        stop_test();
    end
endmodule : cph_cfg_ctrl_bench
